// file: bench/itm_pins.sv
// Far-side pin model: external drivers on pins A and B
`default_nettype none
module itm_pins (
   input wire logic [2:0] pin_a_out,
   input wire logic [2:0] pin_a_oe,
   input wire logic [2:0] ext_a,
   input wire logic [2:0] ext_b,
   output logic [2:0] pin_a_in,
   output logic [2:0] pin_b_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // The channel owns the wire while it drives, so the far side never fights it
   assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & ext_a);
   assign pin_b_in = ext_b;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the idle timer and the three channel timers
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import itm_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic aw_vld = 1'b0, w_vld = 1'b0, ar_vld = 1'b0;
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, idle_irq;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic [31:0] w_data = 32'h0, r_data;
   logic [1:0] b_resp, r_resp;
   logic [2:0] pa_in, pa_out, pa_oe, pb_in, timer_irq;
   logic [2:0] ext_a = 3'h0, ext_b = 3'h0;
   int fail_count = 0, comparisons = 0, cyc = 0;
   itm_mode_t caps [4] = '{ITM_CAP_AP_BP, ITM_CAP_AP_BN, ITM_CAP_AN_BN, ITM_CAP_AN_BNX};

   always #5 aclk = ~aclk;

   itm_top i_itm_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy),
      .s_axi_awaddr(aw_addr), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy), .s_axi_wdata(w_data),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(b_vld), .s_axi_bready(1'b1), .s_axi_bresp(b_resp),
      .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy), .s_axi_araddr(ar_addr), .s_axi_rvalid(r_vld),
      .s_axi_rready(1'b1), .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .pin_a_in(pa_in),
      .pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_in(pb_in), .idle_irq(idle_irq), .timer_irq(timer_irq));
   itm_pins i_itm_pins (.pin_a_out(pa_out), .pin_a_oe(pa_oe), .ext_a(ext_a), .ext_b(ext_b),
      .pin_a_in(pa_in), .pin_b_in(pb_in));

   function automatic logic [31:0] ctl(itm_mode_t m, logic run, logic pa, logic ea, logic pb, logic eb);
      return {24'h0, m, run, pa, ea, pb, eb};
   endfunction
   // Falling-edge triggers per pin; the rest level equals the flag
   function automatic logic fa(itm_mode_t m);
      return m[0];
   endfunction
   function automatic logic fb(itm_mode_t m);
      return m[0] | m[2];
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Ready is read mid-cycle so the handshake edge itself never races the design
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      aw_addr <= a;
      w_data <= d;
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      do begin
         @(negedge aclk);
         aw = aw_rdy;
         w = w_rdy;
         b = b_vld;
         r = b_resp;
         @(posedge aclk);
         if (aw)
            aw_vld <= 1'b0;
         if (w)
            w_vld <= 1'b0;
      end while (!b);
      chk("bresp", er, r);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      logic ar, v;
      logic [1:0] r;
      ar_addr <= a;
      ar_vld <= 1'b1;
      do begin
         @(negedge aclk);
         ar = ar_rdy;
         v = r_vld;
         d = r_data;
         r = r_resp;
         @(posedge aclk);
         if (ar)
            ar_vld <= 1'b0;
      end while (!v);
      chk("rresp", er, r);
   endtask

   task automatic tog(input int ch, output int t);
      logic l;
      @(negedge aclk);
      l = pa_out[ch];
      do @(negedge aclk); while (pa_out[ch] === l);
      t = cyc;
      @(posedge aclk);
   endtask

   task automatic idle_rise(output int t);
      do @(negedge aclk); while (idle_irq !== 1'b1);
      t = cyc;
      @(posedge aclk);
   endtask

   task automatic pulse(input int ch);
      ext_a[ch] <= ~ext_a[ch];
      repeat (4) @(posedge aclk);
      ext_a[ch] <= ~ext_a[ch];
      repeat (4) @(posedge aclk);
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         fail_count++;
         test_done();
      end
   end

   initial begin
      logic [31:0] d, c1, c2, ca;
      logic [7:0] base;
      int a, b, t0, t1, t2, n, ch;
      void'($urandom(32'h51FEB5A5));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("idle irq", 0, idle_irq);
      rd(8'h04, d, 2'h2);
      chk("idle hidden", 0, d);
      wr(8'h00, 32'h1, 2'h0);
      idle_rise(t0);
      wr(8'h00, 32'h1, 2'h0);
      idle_rise(t0);
      wr(8'h00, 32'h1, 2'h0);
      idle_rise(t1);
      chk("idle period", 32'h1000, t1 - t0);
      wr(8'h00, 32'h2, 2'h0);
      chk("idle gated", 0, idle_irq);
      wr(8'h00, 32'h3, 2'h0);
      chk("idle irq on", 1, idle_irq);
      for (ch = 0; ch < 3; ch++) begin
         base = 8'(8'h10 * (ch + 1));
         // Widths above the bus turnaround so no reload slips past a ctrl write
         a = 12 + $urandom % 20;
         b = 12 + $urandom % 20;
         wr(base + 8'h8, 32'hFFFF0000 | a, 2'h0);
         rd(base + 8'h8, d, 2'h0);
         chk("reg a width", a, d);
         wr(base + 8'hC, b, 2'h0);
         wr(base + 8'h4, 32'h8, 2'h0);
         wr(base, ctl(ITM_PWM_TOG, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0), 2'h0);
         tog(ch, t0);
         tog(ch, t1);
         tog(ch, t2);
         chk("pwm a time", a + 1, t1 - t0);
         chk("pwm b time", b + 1, t2 - t1);
         chk("pin a drive", 1, pa_oe[ch]);
         rd(base, d, 2'h0);
         chk("both pending", 32'hA, d & 32'hA);
         chk("irq on a", 1, timer_irq[ch]);
         wr(base, ctl(ITM_PWM_TOG, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1), 2'h0);
         tog(ch, t0);
         chk("no irq a reload", 0, timer_irq[ch]);
         tog(ch, t0);
         chk("irq b reload", 1, timer_irq[ch]);
         wr(base, ctl(ITM_PWM_HOLD, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 2'h0);
         rd(base + 8'h4, c1, 2'h0);
         rd(base + 8'h4, c2, 2'h0);
         chk("halted count", c1, c2);
         chk("hold no drive", 0, pa_oe[ch]);
      end
      for (int i = 0; i < 2; i++) begin
         base = 8'(8'h10 * (i + 1));
         ext_a[i] <= i[0];
         n = 1 + $urandom % 4;
         wr(base + 8'h8, n, 2'h0);
         wr(base + 8'h4, n, 2'h0);
         wr(base, ctl(itm_mode_t'(i), 1'b1, 1'b0, 1'b1, 1'b0, 1'b0), 2'h0);
         repeat (n) pulse(i);
         rd(base + 8'h4, d, 2'h0);
         chk("event count", 0, d);
         chk("no underflow", 0, timer_irq[i]);
         pulse(i);
         chk("underflow irq", 1, timer_irq[i]);
         chk("event no drive", 0, pa_oe[i]);
         wr(base, ctl(itm_mode_t'(i), 1'b1, 1'b0, 1'b0, 1'b0, 1'b1), 2'h0);
         ext_b[i] <= 1'b1;
         repeat (5) @(posedge aclk);
         ext_b[i] <= 1'b0;
         rd(base, d, 2'h0);
         chk("pin b flag", 32'h3, d & 32'hB);
      end
      foreach (caps[i]) begin
         ch = i % 3;
         base = 8'(8'h10 * (ch + 1));
         ext_a[ch] <= fa(caps[i]);
         ext_b[ch] <= fb(caps[i]);
         wr(base + 8'h4, 32'hF000, 2'h0);
         wr(base, ctl(caps[i], 1'b0, 1'b0, 1'b1, 1'b0, 1'b1), 2'h0);
         rd(base + 8'h4, c1, 2'h0);
         ext_a[ch] <= ~fa(caps[i]);
         ext_b[ch] <= ~fb(caps[i]);
         repeat (6) @(posedge aclk);
         rd(base + 8'h4, c2, 2'h0);
         rd(base + 8'h8, ca, 2'h0);
         chk("capture a", 1, ca < c1 && ca > c2);
         rd(base + 8'hC, d, 2'h0);
         chk("capture b", 1, d < c1 && d > c2);
         rd(base, d, 2'h0);
         chk("capture flags", 32'hA, d & 32'hA);
         chk("capture irq", 1, timer_irq[ch]);
         ext_a[ch] <= fa(caps[i]);
         repeat (6) @(posedge aclk);
         rd(base + 8'h8, d, 2'h0);
         chk("other edge", ca, d);
         wr(base, ctl(caps[i], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0), 2'h0);
         wr(base + 8'h4, 32'h3, 2'h0);
         repeat (8) @(posedge aclk);
         rd(base, d, 2'h0);
         chk("underflow flag", 32'h10, d & 32'h18);
         chk("underflow irq", 1, timer_irq[ch]);
      end
      // Falling B trigger lands on the very edge that writes ctrl with pending B clear
      ext_b[0] <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_b[0] <= 1'b0;
      @(posedge aclk);
      wr(8'h10, ctl(ITM_CAP_AN_BNX, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0), 2'h0);
      rd(8'h10, d, 2'h0);
      chk("set beats clear", 32'h2, d & 32'h2);
      test_done();
   end
endmodule
`default_nettype wire

// file: hw/itm_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
`default_nettype none
`include "itm_regs.svh"
module itm_axil (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   import itm_pkg::*;

   itm_axil_t st_ff;
   itm_axil_t nxt_st;

   // Ready gated by ce so that nothing is taken while state is frozen
   assign s_axi_awready = ce & ~st_ff.aw_full & ~st_ff.bvalid;
   assign s_axi_wready = ce & ~st_ff.w_full & ~st_ff.bvalid;
   assign s_axi_arready = ce & ~st_ff.rvalid;
   assign wr_en = ce & st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;
   assign wr_addr = st_ff.awaddr;
   assign wr_data = st_ff.wdata;
   assign wr_strb = st_ff.wstrb;
   assign rd_addr = s_axi_araddr;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;

   always_comb begin
      nxt_st = st_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_full = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_full = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (wr_en) begin
         nxt_st.aw_full = 1'b0;
         nxt_st.w_full = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = wr_err ? `ITM_RESP_ERR : `ITM_RESP_OK;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_data;
         nxt_st.rresp = rd_err ? `ITM_RESP_ERR : `ITM_RESP_OK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end
endmodule
`default_nettype wire

// file: hw/itm_pkg.sv
// Types shared by the timer block modules
`default_nettype none
package itm_pkg;
   typedef enum logic [2:0] {
      ITM_EVT_RISE = 3'b000,
      ITM_EVT_FALL = 3'b001,
      ITM_CAP_AP_BP = 3'b010,
      ITM_CAP_AN_BN = 3'b011,
      ITM_PWM_HOLD = 3'b100,
      ITM_PWM_TOG = 3'b101,
      ITM_CAP_AP_BN = 3'b110,
      ITM_CAP_AN_BNX = 3'b111
   } itm_mode_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] rca;
      logic [15:0] rcb;
      itm_mode_t mode;
      logic run;
      logic pnda;
      logic ena;
      logic pndb;
      logic enb;
      logic sel_b;
      logic pin_out;
      logic a_q;
      logic b_q;
   } itm_chan_t;

   typedef struct packed {
      itm_chan_t [2:0] ch;
      logic [15:0] idle;
      logic idle_en;
      logic idle_pnd;
   } itm_state_t;

   typedef struct packed {
      logic aw_full;
      logic w_full;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } itm_axil_t;
endpackage
`default_nettype wire

// file: hw/itm_regs.svh
// Register offsets, field positions and reset values of the timer block
`ifndef ITM_REGS_SVH
`define ITM_REGS_SVH

// Byte address width; channel n sits at 0x10*(n+1), register index in bits 3:2
`define ITM_AW 8
`define ITM_A_IDLE 8'h00
`define ITM_NCH 3
`define ITM_R_CTRL 2'h0
`define ITM_R_CNT 2'h1
`define ITM_R_RCA 2'h2
`define ITM_R_RCB 2'h3

// Channel control byte
`define ITM_F_ENB 0
`define ITM_F_PNDB 1
`define ITM_F_ENA 2
`define ITM_F_PNDA 3
`define ITM_F_RUN 4
`define ITM_F_MODE 5

// Idle control word
`define ITM_F_IDLE_EN 0
`define ITM_F_IDLE_PND 1

// Twelfth bit: one toggle every 4096 instruction cycles
`define ITM_IDLE_BIT 12
`define ITM_IDLE_RST 16'h0000

`define ITM_RESP_OK 2'h0
`define ITM_RESP_ERR 2'h2

`endif

// file: hw/itm_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module itm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } itm_sync_t;

   itm_sync_t st_ff;
   itm_sync_t nxt_st;

   // First stage feeds only the second stage
   always_comb begin
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.s2;
endmodule
`default_nettype wire

// file: hw/itm_top.sv
// Idle timer and three PWM / event / capture timers behind AXI4-Lite
//
// Function
// - Idle timer counts down, software cannot access.
// - Twelfth-bit toggle sets idle pending flag.
// - Idle enable gates the idle interrupt.
// - Each channel: 16-bit counter, registers A, B.
// - Channel counters and A/B registers have no reset.
// - Pin A bidirectional, pin B input only.
// - Three mode bits select PWM, event, capture.
// - Run bit starts/stops PWM and event counter.
// - PWM counter decrements every instruction cycle.
// - PWM reloads A first, then B, A alternately.
// - Toggle variant inverts pin A per underflow.
// - PWM underflows set pending A/B alternately.
// - Enable A interrupts on reload from A.
// - Enable B interrupts on reload from B.
// - Event mode counts selected pin A edge.
// - Event underflow sets pending A, gated irq.
// - Event mode: pin B rise sets pending B.
// - Event mode never drives pin A.
// - Capture: free count, edges copy count to A/B.
// - Capture edge polarities per pin by mode.
// - Capture registers readable without disturbing counter.
// - Capture triggers set pending A/B, gated irq.
// - Capture underflow sets run bit, gated by A.
`default_nettype none
`include "itm_regs.svh"
module itm_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [2:0] pin_a_in,
   output logic [2:0] pin_a_out,
   output logic [2:0] pin_a_oe,
   input wire logic [2:0] pin_b_in,
   output logic idle_irq,
   output logic [2:0] timer_irq
);
   import itm_pkg::*;

   itm_state_t st_ff;
   itm_state_t nxt_st;
   logic [5:0] pin_s;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;
   logic [2:0] trig_a;
   logic [2:0] trig_b;
   logic [2:0] uflow;

   // Pins are asynchronous to aclk
   itm_sync #(
      .WIDTH(6)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .din({pin_b_in, pin_a_in}),
      .dout(pin_s)
   );

   itm_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] d,
      input logic [3:0] strb
   );
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = d[7:0];
      end
      if (strb[1]) begin
         v[15:8] = d[15:8];
      end
      return v;
   endfunction

   // Unmapped: anything above the last channel, or gaps in the idle slot
   always_comb begin
      wr_err = (wr_addr[7:4] > 4'(`ITM_NCH))
         || (wr_addr[7:4] == 4'h0 && wr_addr[3:2] != 2'h0);
   end

   always_comb begin
      logic [2:0] md;
      logic pwm;
      logic evt;
      logic cap;
      logic ar;
      logic af;
      logic br;
      logic bf;
      logic hit;
      logic cnt_wr;
      logic dec;
      md = 3'h0;
      pwm = 1'b0;
      evt = 1'b0;
      cap = 1'b0;
      ar = 1'b0;
      af = 1'b0;
      br = 1'b0;
      bf = 1'b0;
      hit = 1'b0;
      cnt_wr = 1'b0;
      dec = 1'b0;
      nxt_st = st_ff;
      trig_a = '0;
      trig_b = '0;
      uflow = '0;
      // Free-running; no address reaches the count itself
      nxt_st.idle = st_ff.idle - 16'h0001;
      if (wr_en && wr_addr == `ITM_A_IDLE && wr_strb[0]) begin
         nxt_st.idle_en = wr_data[`ITM_F_IDLE_EN];
         nxt_st.idle_pnd = wr_data[`ITM_F_IDLE_PND];
      end
      if (nxt_st.idle[`ITM_IDLE_BIT] != st_ff.idle[`ITM_IDLE_BIT]) begin
         nxt_st.idle_pnd = 1'b1;
      end
      for (int n = 0; n < `ITM_NCH; n++) begin
         md = st_ff.ch[n].mode;
         pwm = md[2] & ~md[1];
         evt = ~md[2] & ~md[1];
         cap = md[1];
         ar = pin_s[n] & ~st_ff.ch[n].a_q;
         af = ~pin_s[n] & st_ff.ch[n].a_q;
         br = pin_s[n + 3] & ~st_ff.ch[n].b_q;
         bf = ~pin_s[n + 3] & st_ff.ch[n].b_q;
         nxt_st.ch[n].a_q = pin_s[n];
         nxt_st.ch[n].b_q = pin_s[n + 3];
         hit = wr_en && (wr_addr[7:4] == 4'(n + 1));
         cnt_wr = hit && (wr_addr[3:2] == `ITM_R_CNT);
         // Software first, so hardware events below override a clear
         if (hit) begin
            unique case (wr_addr[3:2])
               `ITM_R_CTRL: begin
                  if (wr_strb[0]) begin
                     nxt_st.ch[n].mode = itm_mode_t'(wr_data[`ITM_F_MODE +: 3]);
                     nxt_st.ch[n].run = wr_data[`ITM_F_RUN];
                     nxt_st.ch[n].pnda = wr_data[`ITM_F_PNDA];
                     nxt_st.ch[n].ena = wr_data[`ITM_F_ENA];
                     nxt_st.ch[n].pndb = wr_data[`ITM_F_PNDB];
                     nxt_st.ch[n].enb = wr_data[`ITM_F_ENB];
                     // Restarts the A-first reload order
                     nxt_st.ch[n].sel_b = 1'b0;
                  end
               end
               `ITM_R_CNT: begin
                  nxt_st.ch[n].cnt = merge16(st_ff.ch[n].cnt, wr_data, wr_strb);
               end
               `ITM_R_RCA: begin
                  nxt_st.ch[n].rca = merge16(st_ff.ch[n].rca, wr_data, wr_strb);
               end
               `ITM_R_RCB: begin
                  nxt_st.ch[n].rcb = merge16(st_ff.ch[n].rcb, wr_data, wr_strb);
               end
            endcase
         end
         // Capture ignores the run bit; it is the underflow flag there
         dec = cap | (st_ff.ch[n].run & (pwm | (evt & (md[0] ? af : ar))));
         // A counter write in the same cycle beats the count step
         if (dec && !cnt_wr) begin
            if (st_ff.ch[n].cnt == 16'h0000) begin
               uflow[n] = 1'b1;
               if (pwm) begin
                  if (st_ff.ch[n].sel_b) begin
                     nxt_st.ch[n].cnt = st_ff.ch[n].rcb;
                     nxt_st.ch[n].pndb = 1'b1;
                  end else begin
                     nxt_st.ch[n].cnt = st_ff.ch[n].rca;
                     nxt_st.ch[n].pnda = 1'b1;
                  end
                  nxt_st.ch[n].sel_b = ~st_ff.ch[n].sel_b;
                  if (md[0]) begin
                     nxt_st.ch[n].pin_out = ~st_ff.ch[n].pin_out;
                  end
               end else if (evt) begin
                  nxt_st.ch[n].cnt = st_ff.ch[n].rca;
                  nxt_st.ch[n].pnda = 1'b1;
               end else begin
                  nxt_st.ch[n].cnt = 16'hFFFF;
                  nxt_st.ch[n].run = 1'b1;
               end
            end else begin
               nxt_st.ch[n].cnt = st_ff.ch[n].cnt - 16'h0001;
            end
         end
         if (cap) begin
            trig_a[n] = md[0] ? af : ar;
            trig_b[n] = (md[0] | md[2]) ? bf : br;
            if (trig_a[n]) begin
               nxt_st.ch[n].rca = st_ff.ch[n].cnt;
               nxt_st.ch[n].pnda = 1'b1;
            end
            if (trig_b[n]) begin
               nxt_st.ch[n].rcb = st_ff.ch[n].cnt;
               nxt_st.ch[n].pndb = 1'b1;
            end
         end else if (evt && br) begin
            nxt_st.ch[n].pndb = 1'b1;
         end
      end
   end

   // Reads have no side effect on any count
   always_comb begin
      rd_data = '0;
      rd_err = (rd_addr[7:4] > 4'(`ITM_NCH))
         || (rd_addr[7:4] == 4'h0 && rd_addr[3:2] != 2'h0);
      // Gaps in the idle slot read as zero, like any other unmapped word
      if (rd_addr == `ITM_A_IDLE) begin
         rd_data[`ITM_F_IDLE_EN] = st_ff.idle_en;
         rd_data[`ITM_F_IDLE_PND] = st_ff.idle_pnd;
      end
      for (int n = 0; n < `ITM_NCH; n++) begin
         if (rd_addr[7:4] == 4'(n + 1)) begin
            unique case (rd_addr[3:2])
               `ITM_R_CTRL: begin
                  rd_data[`ITM_F_MODE +: 3] = st_ff.ch[n].mode;
                  rd_data[`ITM_F_RUN] = st_ff.ch[n].run;
                  rd_data[`ITM_F_PNDA] = st_ff.ch[n].pnda;
                  rd_data[`ITM_F_ENA] = st_ff.ch[n].ena;
                  rd_data[`ITM_F_PNDB] = st_ff.ch[n].pndb;
                  rd_data[`ITM_F_ENB] = st_ff.ch[n].enb;
               end
               `ITM_R_CNT: rd_data[15:0] = st_ff.ch[n].cnt;
               `ITM_R_RCA: rd_data[15:0] = st_ff.ch[n].rca;
               `ITM_R_RCB: rd_data[15:0] = st_ff.ch[n].rcb;
            endcase
         end
      end
   end

   always_comb begin
      idle_irq = st_ff.idle_en & st_ff.idle_pnd;
      for (int n = 0; n < `ITM_NCH; n++) begin
         // Pin A is driven only by the toggling PWM; else it is an input
         pin_a_oe[n] = (st_ff.ch[n].mode == ITM_PWM_TOG);
         pin_a_out[n] = st_ff.ch[n].pin_out;
         // In capture the A request merges trigger and underflow
         timer_irq[n] = (st_ff.ch[n].ena & (st_ff.ch[n].pnda
            | (st_ff.ch[n].mode[1] & st_ff.ch[n].run)))
            | (st_ff.ch[n].enb & st_ff.ch[n].pndb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff.idle <= `ITM_IDLE_RST;
         st_ff.idle_en <= 1'b0;
         st_ff.idle_pnd <= 1'b0;
         // Count and A/B stay as they were: power-up contents are undefined
         for (int n = 0; n < `ITM_NCH; n++) begin
            st_ff.ch[n].mode <= ITM_EVT_RISE;
            st_ff.ch[n].run <= 1'b0;
            st_ff.ch[n].pnda <= 1'b0;
            st_ff.ch[n].ena <= 1'b0;
            st_ff.ch[n].pndb <= 1'b0;
            st_ff.ch[n].enb <= 1'b0;
            st_ff.ch[n].sel_b <= 1'b0;
            st_ff.ch[n].pin_out <= 1'b0;
            st_ff.ch[n].a_q <= 1'b0;
            st_ff.ch[n].b_q <= 1'b0;
         end
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Checks on channel 0; the other two share the same loop body
   itm_chan_t c0;
   logic w0;
   logic pwm0;
   assign c0 = st_ff.ch[0];
   assign w0 = wr_en && wr_addr[7:4] == 4'h1;
   assign pwm0 = c0.mode[2] & ~c0.mode[1];

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_pwm_uf;
      ce && pwm0 && c0.run && c0.cnt == 16'h0000 && !w0;
   endsequence

   sequence s_pwm_uf_a;
      s_pwm_uf and !c0.sel_b;
   endsequence

   sequence s_pwm_uf_b;
      s_pwm_uf and c0.sel_b;
   endsequence

   a_idle_count_down: assert property (
      ce |=> st_ff.idle == $past(st_ff.idle) - 16'h0001)
      else $error("idle timer did not decrement");

   a_idle_tick_set: assert property (
      ce && st_ff.idle[12:0] == 13'h0000 |=> st_ff.idle_pnd)
      else $error("idle tick did not set pending");

   a_idle_irq_gate: assert property (
      $rose(idle_irq) |-> st_ff.idle_en && st_ff.idle_pnd && !$past(idle_irq))
      else $error("idle irq raised without enable and pending");

   a_pwm_step_down: assert property (
      ce && pwm0 && c0.run && c0.cnt != 16'h0000 && !w0 |=> c0.cnt == $past(c0.cnt) - 16'h0001)
      else $error("pwm counter did not decrement");

   a_pwm_reload_a: assert property (
      s_pwm_uf_a |=> c0.cnt == $past(c0.rca) && c0.sel_b && c0.pnda)
      else $error("pwm underflow did not reload from A");

   a_pwm_reload_b: assert property (
      s_pwm_uf_b |=> c0.cnt == $past(c0.rcb) && !c0.sel_b && c0.pndb)
      else $error("pwm underflow did not reload from B");

   a_pwm_irq_a: assert property (
      s_pwm_uf_a ##0 c0.ena |=> timer_irq[0])
      else $error("no interrupt on reload from A");

   a_pwm_irq_b: assert property (
      s_pwm_uf_b ##0 c0.enb |=> timer_irq[0])
      else $error("no interrupt on reload from B");

   a_pwm_pin_toggle: assert property (
      s_pwm_uf ##0 c0.mode == ITM_PWM_TOG |=> pin_a_out[0] != $past(pin_a_out[0]))
      else $error("pin A did not toggle on underflow");

   a_evt_no_drive: assert property (
      !c0.mode[2] && !c0.mode[1] |-> !pin_a_oe[0])
      else $error("pin A driven in event counter mode");

   a_cap_copy_a: assert property (
      ce && trig_a[0] && !w0 |=> c0.rca == $past(c0.cnt) && c0.pnda)
      else $error("capture A did not copy the count");

   a_cap_uflow_flag: assert property (
      ce && c0.mode[1] && c0.cnt == 16'h0000 && !w0 |=> c0.run && c0.cnt == 16'hFFFF)
      else $error("capture underflow did not set the flag");

   a_set_over_clear: assert property (
      ce && trig_b[0] && w0 && wr_addr[3:2] == 2'h0 |=> c0.pndb)
      else $error("pending B lost to a software clear");
endmodule
`default_nettype wire
